/* File: include/wsci_pkg.sv */
/*
 Package for the word-serial command interpreter: command codes, field positions,
 response bit positions, reset values, state encoding and carrier structs.
 Assumes one clock and one asynchronous active-low reset.
*/
package wsci_pkg;
	localparam logic [15:0] WSCI_CMD_ABORT     = 16'hc8ff;
	localparam logic [15:0] WSCI_CMD_BYTE_REQ  = 16'hdeff;
	localparam logic [7:0]  WSCI_OP_ASYNC      = 8'ha8;
	localparam logic [7:0]  WSCI_OP_BEGIN_A    = 8'hfc;
	localparam logic [7:0]  WSCI_OP_BEGIN_B    = 8'hfd;
	localparam logic [7:0]  WSCI_LOW_ALL_ONES  = 8'hff;
	localparam logic [6:0]  WSCI_OP_BYTE_AVAIL = 7'h5e;
	localparam logic [7:0]  WSCI_LINE_FEED     = 8'h0a;
	localparam logic [15:0] WSCI_ABORT_REPLY   = 16'hfffe;
	localparam logic [15:0] WSCI_IDLE_REPLY    = 16'hffff;
	localparam int WSCI_ASYNC_EN_N_BIT = 2;
	localparam int WSCI_ASYNC_MODE_BIT = 0;
	localparam int WSCI_RSP_DOR   = 13;
	localparam int WSCI_RSP_DIR   = 12;
	localparam int WSCI_RSP_ERR_N = 11;
	localparam int WSCI_RSP_RR    = 10;
	localparam int WSCI_RSP_WR    = 9;
	localparam int WSCI_RSP_FHS_N = 8;
	localparam logic [1:0] WSCI_RSP_TOP_ONES = 2'h3;
	localparam logic [7:0] WSCI_RSP_LOW_ONES = 8'hff;
	localparam logic       WSCI_EVT_EN_RESET = 1'h1;

	typedef enum logic [1:0] {
		WSCI_IDLE   = 2'h0,
		WSCI_EXEC   = 2'h1,
		WSCI_WAIT_B = 2'h2
	} wsci_state_type;

	// Byte stream toward and from the instrument
	typedef struct packed {
		logic       valid;
		logic [8:0] payload;
	} wsci_byte_in_type;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} wsci_byte_out_type;
endpackage

/* File: logic/wsci_decode.sv */
/*
 Command classifier for the word-serial interpreter: turns a data-low word into a
 one-hot command class. Purely combinational; assumes a stable registered input.
*/
`timescale 1ns/1ps
`default_nettype none
module wsci_decode
	import wsci_pkg::*;
(
	input  wire logic [15:0] cmd,
	output logic             is_abort,
	output logic             is_async,
	output logic             is_begin,
	output logic             is_avail,
	output logic             is_breq,
	output logic             is_unknown
);
	always_comb begin
		is_abort = (cmd == WSCI_CMD_ABORT);
		is_async = (cmd[15:8] == WSCI_OP_ASYNC);
		is_begin = ((cmd[15:8] == WSCI_OP_BEGIN_A) || (cmd[15:8] == WSCI_OP_BEGIN_B))
			&& (cmd[7:0] == WSCI_LOW_ALL_ONES);
		is_avail = (cmd[15:9] == WSCI_OP_BYTE_AVAIL);
		is_breq  = (cmd == WSCI_CMD_BYTE_REQ);
		is_unknown = !(is_abort || is_async || is_begin || is_avail || is_breq);
	end
endmodule
`default_nettype wire

/* File: logic/wsci_core.sv */
/*
 Word-serial command interpreter, servant side. Holds the handshake response
 register and the command/data word register; data-low writes are commands.
 Assumes the commander's write and read strobes are one-cycle pulses on clk and
 that the instrument side answers byte requests through its byte stream.
*/
`timescale 1ns/1ps
`default_nettype none
module wsci_core
	import wsci_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              data_low_wr,
	input  wire logic [15:0]       data_low_wdata,
	input  wire logic              data_low_rd,
	input  wire logic              fast_handshake_on,
	input  wire logic              module_irq_enable,
	input  wire logic              request_true_evt,
	input  wire logic              inst_in_ready,
	input  wire wsci_byte_out_type inst_reply,
	output logic [15:0]            command_data_word,
	output logic [15:0]            handshake_response,
	output wsci_byte_in_type       inst_byte,
	output logic                   inst_byte_req,
	output logic                   inst_reply_taken,
	output logic                   config_default,
	output logic                   events_enabled,
	output logic                   request_irq
);
	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		wsci_state_type    st;
		logic [15:0]       cmd;
		logic [15:0]       dlow;
		logic              rd_ready;
		logic              wr_ready;
		logic              err_n;
		logic              fhs_n;
		logic              evt_en;
		logic              irq_on;
		logic              irq_pend;
		logic              irq_out;
		logic              reply_wait;
		wsci_byte_in_type  byte_out;
		logic              breq;
		logic              taken;
		logic              cfg_def;
		logic              dir;
		logic              output_ready;
		logic [15:0]       rsp;
	} wsci_core_state_type;

	localparam wsci_core_state_type WSCI_CORE_RESET = '{
		st: WSCI_IDLE, cmd: 16'hffff, dlow: WSCI_IDLE_REPLY,
		rd_ready: 1'h0, wr_ready: 1'h1, err_n: 1'h1, fhs_n: 1'h1,
		evt_en: WSCI_EVT_EN_RESET, irq_on: 1'h0, irq_pend: 1'h0, irq_out: 1'h0,
		reply_wait: 1'h0, byte_out: '0, breq: 1'h0, taken: 1'h0,
		cfg_def: 1'h0, dir: 1'h1, output_ready: 1'h1, rsp: 16'hfbff
	};

	wsci_core_state_type s_ff;
	wsci_core_state_type nxt_s;

	logic is_abort;
	logic is_async;
	logic is_begin;
	logic is_avail;
	logic is_breq;
	logic is_unknown;

	// ************************************************************
	// Command decode
	// ************************************************************
	wsci_decode u_decode (
		.cmd        (s_ff.cmd),
		.is_abort   (is_abort),
		.is_async   (is_async),
		.is_begin   (is_begin),
		.is_avail   (is_avail),
		.is_breq    (is_breq),
		.is_unknown (is_unknown)
	);

	// ************************************************************
	// Word builders
	// ************************************************************
	// Response register image; fixed fields always read as ones
	function automatic logic [15:0] rsp_word(input wsci_core_state_type s);
		logic [15:0] w;
		w = {WSCI_RSP_TOP_ONES, 6'h00, WSCI_RSP_LOW_ONES};
		w[WSCI_RSP_DOR]   = s.output_ready;
		w[WSCI_RSP_DIR]   = s.dir;
		w[WSCI_RSP_ERR_N] = s.err_n;
		w[WSCI_RSP_RR]    = s.rd_ready;
		w[WSCI_RSP_WR]    = s.wr_ready;
		w[WSCI_RSP_FHS_N] = s.fhs_n;
		return w;
	endfunction

	// Byte-request reply: end bit set for a line feed
	function automatic logic [15:0] reply_word(input logic [7:0] d);
		logic end_mark;
		end_mark = (d == WSCI_LINE_FEED);
		return {7'h7f, end_mark, d};
	endfunction

	// Async reply: only the disable state is live, bit 1 one, bit 0 zero
	function automatic logic [15:0] async_word(input logic en);
		return {13'h1fff, !en, 1'h1, 1'h0};
	endfunction

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		nxt_s = s_ff;
		nxt_s.byte_out.valid = 1'h0;
		nxt_s.breq           = 1'h0;
		nxt_s.taken          = 1'h0;
		nxt_s.cfg_def        = 1'h0;
		nxt_s.fhs_n          = !fast_handshake_on;
		nxt_s.dir            = inst_in_ready;

		if (data_low_rd) begin
			nxt_s.rd_ready = 1'h0;
		end

		case (s_ff.st)
			WSCI_IDLE: begin
				if (data_low_wr) begin
					nxt_s.cmd      = data_low_wdata;
					nxt_s.wr_ready = 1'h0;
					nxt_s.st       = WSCI_EXEC;
				end
			end
			WSCI_EXEC: begin
				nxt_s.st       = WSCI_IDLE;
				nxt_s.wr_ready = 1'h1;
				if (is_abort) begin
					nxt_s.irq_pend = 1'h0;
					nxt_s.evt_en   = 1'h1;
					nxt_s.irq_on   = 1'h0;
					nxt_s.err_n    = 1'h1;
					nxt_s.rd_ready = 1'h1;
					nxt_s.reply_wait = 1'h0;
					nxt_s.cfg_def  = 1'h1;
					nxt_s.dlow     = WSCI_ABORT_REPLY;
				end else if (is_async) begin
					// Nonzero mode bit forces events off
					nxt_s.evt_en = !s_ff.cmd[WSCI_ASYNC_EN_N_BIT]
						&& !s_ff.cmd[WSCI_ASYNC_MODE_BIT];
					nxt_s.dlow = async_word(nxt_s.evt_en);
					nxt_s.rd_ready = 1'h1;
				end else if (is_begin) begin
					nxt_s.irq_on = 1'h1;
				end else if (is_avail) begin
					nxt_s.byte_out.valid   = 1'h1;
					nxt_s.byte_out.payload = s_ff.cmd[8:0];
				end else if (is_breq) begin
					nxt_s.breq       = 1'h1;
					nxt_s.reply_wait = 1'h1;
					nxt_s.wr_ready   = 1'h0;
					nxt_s.st         = WSCI_WAIT_B;
				end else begin
					nxt_s.err_n = 1'h0;
				end
			end
			WSCI_WAIT_B: begin
				if (inst_reply.valid) begin
					nxt_s.taken = 1'h1;
					nxt_s.dlow  = reply_word(inst_reply.data);
					nxt_s.rd_ready   = 1'h1;
					nxt_s.reply_wait = 1'h0;
					nxt_s.wr_ready   = 1'h1;
					nxt_s.st         = WSCI_IDLE;
				end
			end
			default: begin
				nxt_s.st = WSCI_IDLE;
			end
		endcase

		// Request-true interrupt needs begin, module enable and event enable
		if (request_true_evt && s_ff.evt_en) begin
			nxt_s.irq_pend = 1'h1;
		end
		if (!nxt_s.irq_on) begin
			nxt_s.irq_pend = 1'h0;
		end
		nxt_s.irq_out = nxt_s.irq_pend && nxt_s.irq_on && module_irq_enable;

		// Ready-to-return drops in the same cycle the request starts waiting
		nxt_s.output_ready = !nxt_s.reply_wait;
		nxt_s.rsp = rsp_word(nxt_s);
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_ff <= WSCI_CORE_RESET;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	always_comb begin
		command_data_word  = s_ff.dlow;
		handshake_response = s_ff.rsp;
		inst_byte          = s_ff.byte_out;
		inst_byte_req      = s_ff.breq;
		inst_reply_taken   = s_ff.taken;
		config_default     = s_ff.cfg_def;
		events_enabled     = s_ff.evt_en;
		request_irq        = s_ff.irq_out;
	end
endmodule
`default_nettype wire

/* File: bench/wsci_props.sv */
/* Port checker for wsci_core.
 Assumes it is bound to every wsci_core instance. */
`timescale 1ns/1ps
`default_nettype none
module wsci_props
	import wsci_pkg::*;
(
	input wire logic              clk,
	input wire logic              rst_n,
	input wire logic              data_low_wr,
	input wire logic [15:0]       data_low_wdata,
	input wire logic              data_low_rd,
	input wire logic              fast_handshake_on,
	input wire logic              inst_in_ready,
	input wire wsci_byte_out_type inst_reply,
	input wire logic [15:0]       command_data_word,
	input wire logic [15:0]       handshake_response,
	input wire wsci_byte_in_type  inst_byte,
	input wire logic              inst_byte_req,
	input wire logic              inst_reply_taken,
	input wire logic              config_default,
	input wire logic              module_irq_enable,
	input wire logic              events_enabled,
	input wire logic              request_irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_take(logic [15:0] w);
		data_low_wr && handshake_response[9] && data_low_wdata == w;
	endsequence
	chk_fhs_level: assert property (
		##1 handshake_response[WSCI_RSP_FHS_N] == !$past(fast_handshake_on))
		else $error("fast handshake bit wrong");
	chk_const_ones: assert property (
		handshake_response[7:0] == WSCI_RSP_LOW_ONES)
		else $error("response low byte not ones");
	chk_wr_drop: assert property (
		data_low_wr && handshake_response[WSCI_RSP_WR] |=> !handshake_response[WSCI_RSP_WR])
		else $error("write ready kept after command");
	chk_abort_reply: assert property (
		s_take(WSCI_CMD_ABORT) |-> ##2 command_data_word == WSCI_ABORT_REPLY
		&& handshake_response[11:9] == 3'h7 && config_default && events_enabled)
		else $error("abort result wrong");
	chk_rd_clear: assert property (
		data_low_rd && handshake_response[WSCI_RSP_WR] |=> !handshake_response[WSCI_RSP_RR])
		else $error("read ready kept after read");
	chk_breq_pulse: assert property (
		s_take(WSCI_CMD_BYTE_REQ) |-> ##2 inst_byte_req)
		else $error("byte request not passed on");
	chk_reply_word: assert property (
		inst_reply.valid && !handshake_response[WSCI_RSP_DOR] |=> inst_reply_taken
		&& command_data_word[15:8] == {7'h7f, $past(inst_reply.data) == WSCI_LINE_FEED}
		&& command_data_word[7:0] == $past(inst_reply.data) && handshake_response[WSCI_RSP_RR])
		else $error("reply word wrong");
	chk_dir_level: assert property (
		##1 handshake_response[WSCI_RSP_DIR] == $past(inst_in_ready))
		else $error("accept bit wrong");
	chk_err_unknown: assert property (
		data_low_wr && handshake_response[WSCI_RSP_WR] && !data_low_wdata[15]
		|-> ##2 !handshake_response[WSCI_RSP_ERR_N])
		else $error("unknown command not flagged");
	chk_irq_gate: assert property (
		request_irq |-> $past(module_irq_enable))
		else $error("interrupt raised without module enable");
endmodule
bind wsci_core wsci_props u_props (.*);
`default_nettype wire

/* File: bench/wsci_commander.sv */
/* Backplane commander model: writes commands, reads data low.
 Assumes the response register is fed back on rsp. */
`timescale 1ns/1ps
`default_nettype none
module wsci_commander (
	input wire logic        clk,
	input wire logic [15:0] rsp,
	output var logic        wr,
	output var logic [15:0] wdata,
	output var logic        rd
);
	int stalls;
	initial begin
		stalls = 0;
		wr = 1'b0;
		wdata = 16'h0000;
		rd = 1'b0;
	end
	task automatic put(input logic [15:0] w);
		int n;
		n = 0;
		@(posedge clk);
		while (rsp[9] !== 1'b1 && n < 200) begin
			@(posedge clk);
			n++;
		end
		if (rsp[9] !== 1'b1) begin
			stalls++;
		end
		wr <= 1'b1;
		wdata <= w;
		@(posedge clk);
		wr <= 1'b0;
		wdata <= ~w;
	endtask
	task automatic get();
		int n;
		n = 0;
		@(posedge clk);
		while (rsp[10] !== 1'b1 && n < 200) begin
			@(posedge clk);
			n++;
		end
		if (rsp[10] !== 1'b1) begin
			stalls++;
		end
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
	endtask
endmodule
`default_nettype wire

/* File: bench/tb.sv */
/* Self-checking bench for wsci_core.
 Assumes the commander model and bound checker are compiled. */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import wsci_pkg::*;
	logic              clk, rst_n, data_low_wr, data_low_rd, fast_handshake_on;
	logic              module_irq_enable, request_true_evt, inst_in_ready;
	logic [15:0]       data_low_wdata, command_data_word, handshake_response;
	wsci_byte_out_type inst_reply;
	wsci_byte_in_type  inst_byte;
	logic              inst_byte_req, inst_reply_taken, config_default, events_enabled, request_irq;
	int                mismatches, n_compared;
	wsci_core DUT (.*);
	wsci_commander c (.clk(clk), .rsp(handshake_response), .wr(data_low_wr),
		.wdata(data_low_wdata), .rd(data_low_rd));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic stop_test();
		if (mismatches == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic t_pins(input logic on);
		fast_handshake_on <= on;
		inst_in_ready <= !on;
		repeat (3) @(posedge clk);
		chk("fhs_dir", {14'h0, !on, !on}, {14'h0, handshake_response[12], handshake_response[8]});
	endtask
	task automatic t_breq(input logic [7:0] d);
		int n;
		n = 0;
		c.put(WSCI_CMD_BYTE_REQ);
		while (inst_byte_req !== 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		repeat (3) @(posedge clk);
		chk("dor_wait", 16'h0, {15'h0, handshake_response[13]});
		inst_reply <= '{1'b1, d};
		@(posedge clk);
		inst_reply <= '{1'b0, ~d};
		c.get();
		chk("reply", {7'h7f, d == WSCI_LINE_FEED, d}, command_data_word);
		@(posedge clk);
		chk("rr_clear", 16'h0, {15'h0, handshake_response[10]});
		chk("dor_back", 16'h1, {15'h0, handshake_response[13]});
	endtask
	task automatic t_async(input logic [7:0] lo, input logic [15:0] ew, input logic ee);
		c.put({WSCI_OP_ASYNC, lo});
		c.get();
		chk("async_word", ew, command_data_word);
		chk("evt_en", {15'h0, ee}, {15'h0, events_enabled});
	endtask
	task automatic t_avail_unknown();
		int n;
		n = 0;
		c.put({WSCI_OP_BYTE_AVAIL, 9'h1a5});
		while (inst_byte.valid !== 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		chk("avail", 16'h01a5, {7'h0, inst_byte.payload});
		c.put(16'h1234);
		repeat (3) @(posedge clk);
		chk("err_n", 16'h0, {15'h0, handshake_response[11]});
	endtask
	task automatic t_abort_irq();
		c.put(WSCI_CMD_ABORT);
		c.get();
		chk("abort_word", 16'hfffe, command_data_word);
		chk("abort_err", 16'h1, {15'h0, handshake_response[11]});
		module_irq_enable <= 1'b1;
		request_true_evt <= 1'b1;
		repeat (4) @(posedge clk);
		chk("irq_blocked", 16'h0, {15'h0, request_irq});
		c.put({WSCI_OP_BEGIN_B, WSCI_LOW_ALL_ONES});
		repeat (4) @(posedge clk);
		chk("irq_on", 16'h1, {15'h0, request_irq});
		request_true_evt <= 1'b0;
	endtask
	initial begin
		repeat (3000) @(posedge clk);
		mismatches++;
		stop_test();
	end
	initial begin
		rst_n = 1'b0;
		fast_handshake_on = 1'b0;
		module_irq_enable = 1'b0;
		request_true_evt = 1'b0;
		inst_in_ready = 1'b1;
		inst_reply = '0;
		mismatches = 0;
		n_compared = 0;
		repeat (5) @(posedge clk);
		chk("rsp_reset", 16'hfbff, handshake_response);
		rst_n <= 1'b1;
		t_pins(1'b1);
		t_pins(1'b0);
		t_breq(WSCI_LINE_FEED);
		t_breq(8'h41);
		t_async(8'hfa, 16'hfffa, 1'b1);
		t_async(8'h01, 16'hfffe, 1'b0);
		t_async(8'h04, 16'hfffe, 1'b0);
		t_avail_unknown();
		t_abort_irq();
		chk("bus_stalls", 16'h0, 16'(c.stalls));
		stop_test();
	end
endmodule
`default_nettype wire
